// ===== inc/smct_pkg.sv
`default_nettype none
package smct_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_CONFIG = 5'h04;
  localparam logic [4:0] ADDR_BAUD = 5'h08;
  localparam logic [4:0] ADDR_TXDATA = 5'h0C;
  localparam logic [4:0] ADDR_RXDATA = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;

  // ==========================================================
  // field positions
  localparam int CTRL_MASTER_BIT = 2;
  localparam int CTRL_PHASE_BIT = 3;
  localparam int CFG_POL_BIT = 6;
  localparam int CFG_LEN_LSB = 0;
  localparam int CFG_LEN_W = 4;
  localparam int BAUD_W = 7;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RXFULL_BIT = 1;
  localparam int STAT_TXFULL_BIT = 2;
  localparam int STAT_TXEMPTY_BIT = 3;

  // ==========================================================
  // reset values
  localparam logic CTRL_MASTER_RST = 1'b0;
  localparam logic CTRL_PHASE_RST = 1'b0;
  localparam logic CFG_POL_RST = 1'b0;
  localparam logic [3:0] CFG_LEN_RST = 4'hF;
  localparam logic [6:0] BAUD_RST = 7'h7F;

  // ==========================================================
  // clock divider
  localparam logic [6:0] BRR_SMALL_MAX = 7'h02;
  localparam logic [7:0] DIV_FLOOR = 8'h04;
  localparam int CLK_MHZ = 250;
  localparam int SCLK_MAX_MHZ = 20;
  localparam int SCLK_MIN_DIV = (CLK_MHZ + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;

  // ==========================================================
  // frame sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LEAD = 5'h02,
    ST_ACTIVE = 5'h04,
    ST_REST = 5'h08,
    ST_TRAIL = 5'h10
  } smct_state_t;
endpackage
`default_nettype wire

// ===== rtl/smct_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module smct_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  wire logic [AW:0] fill = wrPtr - rdPtr;
  wire logic push = inValid & inReady;
  wire logic pop = outValid & outReady;

  assign inReady = fill != (AW+1)'(DEPTH);
  assign outValid = fill != '0;
  assign outData = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wrPtr[AW-1:0]] <= inData;
  end
endmodule // smct_fifo
`default_nettype wire

// ===== rtl/smct_spi_master.sv
// Contract
// - master drives clock and enable when selected
// - control bit picks clock phase scheme
// - polarity bit picks active clock edge
// - period four, else baud value plus one
// - odd divisor: first half shorter by one cycle
// - enable leads by half period, trails by half period in phase zero only
// - phase zero: shift leading, sample trailing
// - phase one: present early, sample active
`timescale 1ns/100ps
`default_nettype none
module smct_spi_master #(
  parameter int DW = 16,
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [smct_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial pins
  output logic serialClock,
  output logic serialClockOe,
  output logic masterOutData,
  output logic masterOutDataOe,
  output logic slaveEnableN,
  output logic slaveEnableNOe,
  input wire logic masterInData
);
  if (DW != (1 << smct_pkg::CFG_LEN_W)) begin : g_bad
    $error("data width must match the word length field");
  end

  // ==========================================================
  // helpers
  function automatic logic [7:0] sclkPeriod(input logic [6:0] brr);
    sclkPeriod = (brr <= smct_pkg::BRR_SMALL_MAX) ? smct_pkg::DIV_FLOOR
                 : {1'b0, brr} + 8'h01;
  endfunction

  function automatic logic [6:0] firstHalf(input logic [7:0] per);
    firstHalf = per[7:1];
  endfunction

  // ==========================================================
  // declarations
  smct_pkg::smct_state_t state;
  smct_pkg::smct_state_t next_state;
  logic ctrlMaster;
  logic ctrlPhase;
  logic cfgPol;
  logic [smct_pkg::CFG_LEN_W-1:0] cfgLen;
  logic [smct_pkg::BAUD_W-1:0] baudRate;
  logic frmPhase;
  logic frmPol;
  logic [smct_pkg::CFG_LEN_W-1:0] frmLen;
  logic [7:0] frmPeriod;
  logic [6:0] tmr;
  logic [smct_pkg::CFG_LEN_W-1:0] bitIdx;
  logic [DW-1:0] txShift;
  logic [DW-1:0] rxShift;
  logic [DW-1:0] rxData;
  logic rxFull;
  logic rdPending;
  logic misoMeta;
  logic misoSync;
  logic fifoInReady;
  logic fifoOutValid;
  logic [DW-1:0] fifoOutData;
  logic [7:0] stCnt;

  // ==========================================================
  // input synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      misoMeta <= 1'b0;
      misoSync <= 1'b0;
    end else begin
      misoMeta <= masterInData;
      misoSync <= misoMeta;
    end
  end

  // ==========================================================
  // bus decode
  wire logic selCtrl = avs_address == smct_pkg::ADDR_CTRL;
  wire logic selCfg = avs_address == smct_pkg::ADDR_CONFIG;
  wire logic selBaud = avs_address == smct_pkg::ADDR_BAUD;
  wire logic selTx = avs_address == smct_pkg::ADDR_TXDATA;
  wire logic selRx = avs_address == smct_pkg::ADDR_RXDATA;
  wire logic selStat = avs_address == smct_pkg::ADDR_STATUS;
  wire logic rdWait = avs_read & ~rdPending;
  wire logic wrWait = avs_write & selTx & ~fifoInReady;
  wire logic wrTake = avs_write & ~wrWait;
  wire logic rdTake = avs_read & rdPending;
  wire logic lowLane = wrTake & avs_byteenable[0];
  wire logic [31:0] laneMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic [DW-1:0] txWord = avs_writedata[DW-1:0] & laneMask[DW-1:0];
  wire logic busy = state != smct_pkg::ST_IDLE;

  wire logic [31:0] ctrlWord = 32'(({31'h0, ctrlPhase} << smct_pkg::CTRL_PHASE_BIT)
                               | ({31'h0, ctrlMaster} << smct_pkg::CTRL_MASTER_BIT));
  wire logic [31:0] cfgWord = 32'(({31'h0, cfgPol} << smct_pkg::CFG_POL_BIT)
                              | ({28'h0, cfgLen} << smct_pkg::CFG_LEN_LSB));
  wire logic [31:0] statWord = 32'(({31'h0, busy} << smct_pkg::STAT_BUSY_BIT)
                               | ({31'h0, rxFull} << smct_pkg::STAT_RXFULL_BIT)
                               | ({31'h0, ~fifoInReady} << smct_pkg::STAT_TXFULL_BIT)
                               | ({31'h0, ~fifoOutValid} << smct_pkg::STAT_TXEMPTY_BIT));
  wire logic [31:0] rdMux = selCtrl ? ctrlWord
                          : selCfg ? cfgWord
                          : selBaud ? {25'h0, baudRate}
                          : selRx ? {{(32-DW){1'b0}}, rxData}
                          : selStat ? statWord
                          : 32'h0;

  // reads wait one cycle so the answer comes from a flop
  assign avs_waitrequest = rdWait | wrWait;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdPending <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      rdPending <= rdWait;
      if (rdWait) avs_readdata <= rdMux;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlMaster <= smct_pkg::CTRL_MASTER_RST;
      ctrlPhase <= smct_pkg::CTRL_PHASE_RST;
      cfgPol <= smct_pkg::CFG_POL_RST;
      cfgLen <= smct_pkg::CFG_LEN_RST;
      baudRate <= smct_pkg::BAUD_RST;
    end else if (lowLane) begin
      if (selCtrl) begin
        ctrlMaster <= avs_writedata[smct_pkg::CTRL_MASTER_BIT];
        ctrlPhase <= avs_writedata[smct_pkg::CTRL_PHASE_BIT];
      end
      if (selCfg) begin
        cfgPol <= avs_writedata[smct_pkg::CFG_POL_BIT];
        cfgLen <= avs_writedata[smct_pkg::CFG_LEN_LSB +: smct_pkg::CFG_LEN_W];
      end
      if (selBaud) baudRate <= avs_writedata[smct_pkg::BAUD_W-1:0];
    end
  end

  // ==========================================================
  // transmit buffer
  wire logic startFrame = (state == smct_pkg::ST_IDLE) & ctrlMaster & fifoOutValid;

  smct_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_txFifo (
    .clk(clk),
    .rstn(rstn),
    .inValid(avs_write & selTx),
    .inReady(fifoInReady),
    .inData(txWord),
    .outValid(fifoOutValid),
    .outReady(startFrame),
    .outData(fifoOutData)
  );

  // ==========================================================
  // frame sequencer
  wire logic [6:0] halfA = firstHalf(frmPeriod);
  wire logic [6:0] halfB = 7'(frmPeriod - {1'b0, halfA});
  wire logic tmrDone = tmr == 7'h01;
  wire logic lastBit = bitIdx == frmLen;
  wire logic edgeOut = tmrDone & (state == smct_pkg::ST_LEAD | state == smct_pkg::ST_REST);
  wire logic edgeBack = tmrDone & (state == smct_pkg::ST_ACTIVE);
  // phase one samples on the leading edge, phase zero on the trailing one
  wire logic sampleEv = frmPhase ? edgeOut : edgeBack;
  wire logic shiftEv = frmPhase ? (edgeBack & ~lastBit)
                       : (edgeOut & (bitIdx != '0));
  wire logic frameEnd = busy & (next_state == smct_pkg::ST_IDLE);
  wire logic polSel = busy ? frmPol : cfgPol;
  wire logic [DW-1:0] lenMask = {DW{1'b1}} >> (smct_pkg::CFG_LEN_W'(DW - 1) - frmLen);

  always_comb begin
    next_state = state;
    case (state)
      smct_pkg::ST_IDLE: if (startFrame) next_state = smct_pkg::ST_LEAD;
      smct_pkg::ST_LEAD: if (tmrDone) next_state = smct_pkg::ST_ACTIVE;
      smct_pkg::ST_ACTIVE: begin
        if (tmrDone) begin
          if (!lastBit) next_state = smct_pkg::ST_REST;
          else if (frmPhase) next_state = smct_pkg::ST_IDLE;
          else next_state = smct_pkg::ST_TRAIL;
        end
      end
      smct_pkg::ST_REST: if (tmrDone) next_state = smct_pkg::ST_ACTIVE;
      smct_pkg::ST_TRAIL: if (tmrDone) next_state = smct_pkg::ST_IDLE;
      default: next_state = smct_pkg::ST_IDLE;
    endcase
  end

  // active level half is the shorter one on odd divisors
  wire logic [6:0] next_tmr = (next_state == smct_pkg::ST_REST) ? halfB
                              : (state == smct_pkg::ST_IDLE)
                              ? firstHalf(sclkPeriod(baudRate)) : halfA;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= smct_pkg::ST_IDLE;
      tmr <= 7'h01;
    end else begin
      state <= next_state;
      tmr <= (next_state != state) ? next_tmr : tmr - 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frmPhase <= smct_pkg::CTRL_PHASE_RST;
      frmPol <= smct_pkg::CFG_POL_RST;
      frmLen <= smct_pkg::CFG_LEN_RST;
      frmPeriod <= smct_pkg::DIV_FLOOR;
    end else if (startFrame) begin
      frmPhase <= ctrlPhase;
      frmPol <= cfgPol;
      frmLen <= cfgLen;
      frmPeriod <= sclkPeriod(baudRate);
    end
  end

  // ==========================================================
  // shifters and pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bitIdx <= '0;
      txShift <= '0;
      rxShift <= '0;
    end else begin
      if (startFrame) bitIdx <= '0;
      else if (edgeBack) bitIdx <= bitIdx + 1'b1;
      if (startFrame) txShift <= fifoOutData << (smct_pkg::CFG_LEN_W'(DW - 1) - cfgLen);
      else if (shiftEv) txShift <= {txShift[DW-2:0], 1'b0};
      if (sampleEv) rxShift <= {rxShift[DW-2:0], misoSync};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serialClock <= smct_pkg::CFG_POL_RST;
      slaveEnableN <= 1'b1;
      rxData <= '0;
      rxFull <= 1'b0;
    end else begin
      serialClock <= (next_state == smct_pkg::ST_ACTIVE) ^ polSel;
      slaveEnableN <= next_state == smct_pkg::ST_IDLE;
      if (frameEnd) rxData <= rxShift & lenMask;
      // a word that lands while software reads keeps the flag set
      if (frameEnd) rxFull <= 1'b1;
      else if (rdTake & selRx) rxFull <= 1'b0;
    end
  end

  assign masterOutData = txShift[DW-1];
  assign serialClockOe = ctrlMaster;
  assign slaveEnableNOe = ctrlMaster;
  assign masterOutDataOe = ctrlMaster;

  // ==========================================================
  // checks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) stCnt <= 8'h01;
    else stCnt <= (next_state != state) ? 8'h01 : stCnt + 8'h01;
  end

  chk_start_needs_master: assert property (
    @(posedge clk) disable iff (!rstn)
    $fell(slaveEnableN) |-> $past(ctrlMaster) && serialClockOe == ctrlMaster)
    else $error("frame started outside master mode");

  chk_phase_latched: assert property (
    @(posedge clk) disable iff (!rstn)
    startFrame |=> frmPhase == $past(ctrlPhase) && state == smct_pkg::ST_LEAD)
    else $error("frame phase not taken from control bit");

  chk_active_level: assert property (
    @(posedge clk) disable iff (!rstn)
    state == smct_pkg::ST_ACTIVE |-> serialClock == !frmPol && !slaveEnableN)
    else $error("serial clock not at active level");

  chk_period_value: assert property (
    @(posedge clk) disable iff (!rstn)
    startFrame ##1 1'b1 |-> frmPeriod == (($past(baudRate) <= 7'h02) ? 8'h04
                                         : {1'b0, $past(baudRate)} + 8'h01))
    else $error("serial clock period mismatch");

  chk_half_split: assert property (
    @(posedge clk) disable iff (!rstn)
    (state == smct_pkg::ST_REST && next_state == smct_pkg::ST_ACTIVE)
    |-> stCnt == frmPeriod - {1'b0, frmPeriod[7:1]} && $past(stCnt, 1) >= 8'h01)
    else $error("idle half of serial clock wrong length");

  chk_active_half: assert property (
    @(posedge clk) disable iff (!rstn)
    (state == smct_pkg::ST_ACTIVE && next_state != smct_pkg::ST_ACTIVE)
    |-> stCnt == {1'b0, frmPeriod[7:1]})
    else $error("active half of serial clock wrong length");

  chk_enable_lead: assert property (
    @(posedge clk) disable iff (!rstn)
    $fell(slaveEnableN) |-> serialClock == frmPol
    ##0 (state == smct_pkg::ST_LEAD && serialClock == frmPol) [*2])
    else $error("slave enable lead too short");

  chk_enable_trail: assert property (
    @(posedge clk) disable iff (!rstn)
    (state == smct_pkg::ST_TRAIL && next_state == smct_pkg::ST_IDLE)
    |-> stCnt == {1'b0, frmPeriod[7:1]} ##1 slaveEnableN)
    else $error("slave enable trail wrong");

  chk_ph0_shift_edge: assert property (
    @(posedge clk) disable iff (!rstn)
    (!frmPhase && $past(busy) && busy && $changed(masterOutData))
    |-> state == smct_pkg::ST_ACTIVE && $past(state) != smct_pkg::ST_ACTIVE)
    else $error("phase zero data moved off the leading edge");

  chk_ph0_sample: assert property (
    @(posedge clk) disable iff (!rstn)
    (!frmPhase && $past(state) == smct_pkg::ST_ACTIVE && state != smct_pkg::ST_ACTIVE)
    |-> rxShift[0] == $past(misoSync) && serialClock == frmPol)
    else $error("phase zero sample missed the trailing edge");

  chk_ph1_sample: assert property (
    @(posedge clk) disable iff (!rstn)
    (frmPhase && state == smct_pkg::ST_ACTIVE && $past(state) != smct_pkg::ST_ACTIVE)
    |-> rxShift[0] == $past(misoSync) && $stable(masterOutData))
    else $error("phase one sample missed the active edge");

  chk_idle_level: assert property (
    @(posedge clk) disable iff (!rstn)
    (state == smct_pkg::ST_IDLE && $past(state) == smct_pkg::ST_IDLE)
    |-> serialClock == $past(cfgPol))
    else $error("idle clock level does not follow polarity");
endmodule // smct_spi_master
`default_nettype wire

// ===== testbench/smct_spi_slave.sv
`timescale 1ns/100ps
`default_nettype none
module smct_spi_slave (
  // clock
  input wire logic clk,
  // serial pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic enN,
  output logic miso,
  // setup
  input wire logic pol,
  input wire logic phase,
  input wire logic [3:0] lenM1,
  input wire logic [15:0] reply,
  // results
  output logic [15:0] got,
  output logic [7:0] frames
);
  logic [15:0] rxShift;
  int bitIdx;
  initial begin
    miso = 1'b0;
    frames = 8'h00;
    got = 16'h0000;
  end
  // unselected: the line changes every cycle
  always @(posedge clk) if (enN) miso <= ~miso;
  always @(negedge enN) begin
    bitIdx = 0;
    rxShift = 16'h0000;
    miso <= reply[lenM1];
  end
  // sample edge: trailing for phase 0, leading for phase 1
  always @(sclk) if (!enN) begin
    if ((sclk !== pol) == phase) begin
      rxShift = {rxShift[14:0], mosi};
      bitIdx++;
    end else if (bitIdx <= int'(lenM1)) begin
      miso <= reply[int'(lenM1) - bitIdx];
    end
  end
  always @(posedge enN) begin
    got = rxShift;
    frames = frames + 8'h01;
  end
endmodule // smct_spi_slave
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic pol;
    logic phase;
    logic [6:0] baud;
    logic [3:0] lenM1;
    logic [15:0] tx;
    logic [15:0] rx;
  } smct_case_t;
  logic clk, rstn, avs_read, avs_write, masterInData;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, serialClock, serialClockOe, masterOutData, masterOutDataOe;
  logic slaveEnableN, slaveEnableNOe, slavePol, slavePhase;
  logic [3:0] slaveLen;
  logic [15:0] slaveReply, slaveGot;
  logic [7:0] frames, base;
  logic sclkPrev, enPrev, first;
  int cnt, leadLen, actLen, idleLen, trailLen, edges, failures, comparisons, w, i;
  wire logic sclkPin = serialClockOe ? serialClock : slavePol;
  wire logic enPin = slaveEnableNOe ? slaveEnableN : 1'b1;
  wire logic mosiPin = masterOutDataOe ? masterOutData : 1'b1;
  smct_case_t cases [6] = '{
    '{1'b0, 1'b0, 7'h0C, 4'hF, 16'hA5C3, 16'h3C5A},
    '{1'b1, 1'b0, 7'h0F, 4'h7, 16'h00B4, 16'h0069},
    '{1'b0, 1'b1, 7'h0D, 4'hB, 16'h0E71, 16'h0B2D},
    '{1'b1, 1'b1, 7'h10, 4'hF, 16'h8001, 16'h7FFE},
    '{1'b0, 1'b0, 7'h0C, 4'h3, 16'h000D, 16'h0006},
    '{1'b1, 1'b1, 7'h7F, 4'h1, 16'h0002, 16'h0001}
  };

  smct_spi_master u_smct_spi_master (.clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serialClock(serialClock),
    .serialClockOe(serialClockOe), .masterOutData(masterOutData),
    .masterOutDataOe(masterOutDataOe), .slaveEnableN(slaveEnableN),
    .slaveEnableNOe(slaveEnableNOe), .masterInData(masterInData));
  smct_spi_slave u_smct_spi_slave (.clk(clk), .sclk(sclkPin), .mosi(mosiPin), .enN(enPin),
    .miso(masterInData), .pol(slavePol), .phase(slavePhase), .lenM1(slaveLen),
    .reply(slaveReply), .got(slaveGot), .frames(frames));

  // ==========================================================
  // clock and frame timing monitor
  initial clk = 1'b0;
  always #2 clk = ~clk;
  initial begin
    enPrev = 1'b1;
    sclkPrev = 1'b0;
    cnt = 0;
  end
  always @(posedge clk) begin
    if (!enPrev) begin
      if (sclkPin !== sclkPrev) begin
        if (first) leadLen = cnt;
        else if (sclkPrev !== slavePol) actLen = cnt;
        else idleLen = cnt;
        first = 1'b0;
        edges++;
        cnt = 1;
      end else cnt++;
      if (enPin) trailLen = cnt - 1;
    end else if (!enPin) begin
      first = 1'b1;
      cnt = 1;
      edges = 0;
    end
    enPrev = enPin;
    sclkPrev = sclkPin;
  end

  // ==========================================================
  // bus access and checking
  task automatic bus_write(input logic [4:0] a, input logic [31:0] d, output int n);
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 5000);
    avs_write <= 1'b0;
  endtask
  task automatic bus_read(input logic [4:0] a, output logic [31:0] d, output int n);
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 5000);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_frames(input logic [7:0] target);
    int k;
    for (k = 0; k < 20000 && frames !== target; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    check_word("frame count", target, frames);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one word with full timing and data checks
  task automatic run_case(input smct_case_t c);
    int p, a, n;
    logic [31:0] mask;
    p = (c.baud <= smct_pkg::BRR_SMALL_MAX) ? 4 : int'(c.baud) + 1;
    a = p / 2;
    mask = (32'h1 << (int'(c.lenM1) + 1)) - 32'h1;
    slavePol <= c.pol;
    slavePhase <= c.phase;
    slaveLen <= c.lenM1;
    slaveReply <= c.rx;
    bus_write(smct_pkg::ADDR_CONFIG, {25'h0, c.pol, 2'h0, c.lenM1}, n);
    bus_write(smct_pkg::ADDR_BAUD, {25'h0, c.baud}, n);
    bus_write(smct_pkg::ADDR_CTRL, {28'h0, c.phase, 1'b1, 2'h0}, n);
    base = frames;
    bus_write(smct_pkg::ADDR_TXDATA, {16'h0, c.tx}, n);
    wait_frames(base + 8'h01);
    check_word("lead", a, leadLen);
    check_word("active half", a, actLen);
    check_word("idle half", p - a, idleLen);
    check_word("trail", c.phase ? 0 : a, trailLen);
    check_word("edges", 2 * (int'(c.lenM1) + 1), edges);
    check_word("slave got", {16'h0, c.tx} & mask, {16'h0, slaveGot});
    check_word("idle clock", {31'h0, c.pol}, {31'h0, serialClock});
    bus_read(smct_pkg::ADDR_RXDATA, rd, n);
    check_word("rx data", {16'h0, c.rx} & mask, rd);
  endtask

  // ==========================================================
  // tests
  initial begin
    failures = 0;
    comparisons = 0;
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    slavePol = 1'b0;
    slavePhase = 1'b0;
    slaveLen = 4'hF;
    slaveReply = 16'h0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    check_word("oe after reset", 32'h0, {29'h0, serialClockOe, masterOutDataOe, slaveEnableNOe});
    bus_read(smct_pkg::ADDR_CTRL, rd, w);
    check_word("ctrl reset", 32'h0, rd);
    check_word("read answer cycles", 2, w);
    bus_read(smct_pkg::ADDR_CONFIG, rd, w);
    check_word("config reset", {25'h0, smct_pkg::CFG_POL_RST, 2'h0, smct_pkg::CFG_LEN_RST}, rd);
    bus_read(smct_pkg::ADDR_BAUD, rd, w);
    check_word("baud reset", {25'h0, smct_pkg::BAUD_RST}, rd);
    bus_read(5'h18, rd, w);
    check_word("unmapped", 32'h0, rd);
    for (i = 0; i < 6; i++) run_case(cases[i]);
    // buffer: fill with master off, then drain
    slavePol <= 1'b0;
    slavePhase <= 1'b0;
    slaveLen <= 4'h3;
    bus_write(smct_pkg::ADDR_CTRL, 32'h0, w);
    bus_write(smct_pkg::ADDR_CONFIG, 32'h3, w);
    bus_write(smct_pkg::ADDR_BAUD, 32'h0C, w);
    base = frames;
    for (i = 0; i < 4; i++) bus_write(smct_pkg::ADDR_TXDATA, 32'h1230 + i, w);
    bus_read(smct_pkg::ADDR_STATUS, rd, w);
    check_word("tx full", 32'h1, {31'h0, rd[smct_pkg::STAT_TXFULL_BIT]});
    repeat (200) @(posedge clk);
    check_word("no frame when off", {24'h0, base}, {24'h0, frames});
    check_word("pins released", 32'h0, {30'h0, serialClockOe, slaveEnableNOe});
    bus_write(smct_pkg::ADDR_CTRL, 32'h4, w);
    bus_write(smct_pkg::ADDR_TXDATA, 32'h1234, w);
    bus_write(smct_pkg::ADDR_TXDATA, 32'h1235, w);
    check_word("full write held", 32'h1, {31'h0, w > 1});
    wait_frames(base + 8'h06);
    check_word("last word", 32'h5, {16'h0, slaveGot});
    check_word("trail", 6, trailLen);
    bus_read(smct_pkg::ADDR_STATUS, rd, w);
    check_word("tx empty", 32'h1, {31'h0, rd[smct_pkg::STAT_TXEMPTY_BIT]});
    report_and_stop();
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
